// ### rtl/txfq_pkg.sv
// package of constants for the transmit free queue and placement block
// assumes an apb register bus with 32-bit data and one word per register
//
// How it works
// - capacity is 2^(length+1)-1 entries of 16 bits, length up to 15
// - any write to the length register zeroes read and write pointers
// - finished buffer descriptor goes to 256*base+2*wptr, then wptr advances
// - auto read register read bumps rptr modulo capacity+1 while not empty
// - manual read register read never advances; host writes updated rptr back
// - manual register write ignores bits 31..16, updates only rptr
// - writing the auto read register loads the write pointer
// - cell counter increments once per transmit cell clock interval
// - cell counter goes out to the credit manager and is host readable
// - placement bit one selects host memory, zero selects local memory
// - placement register holds twelve separate structure bits
// - base holds 24 upper bits; byte address is base*256 plus offset
package txfq_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_FREE_QUEUE_LENGTH = 8'hc5;
	localparam logic [7:0] IDX_FREE_QUEUE_AUTO_READ = 8'hc8;
	localparam logic [7:0] IDX_FREE_QUEUE_MANUAL_READ = 8'hcb;
	localparam logic [7:0] IDX_CELL_INTERVAL_COUNTER = 8'hcc;
	localparam logic [7:0] IDX_MEMORY_PLACEMENT_SELECT = 8'hcd;
	localparam logic [7:0] IDX_FREE_QUEUE_BASE = 8'hc2;
	localparam int ADDR_W = 10;
	localparam logic [9:0] ADDR_FREE_QUEUE_LENGTH = {IDX_FREE_QUEUE_LENGTH, 2'b00};
	localparam logic [9:0] ADDR_FREE_QUEUE_AUTO_READ = {IDX_FREE_QUEUE_AUTO_READ, 2'b00};
	localparam logic [9:0] ADDR_FREE_QUEUE_MANUAL_READ = {IDX_FREE_QUEUE_MANUAL_READ, 2'b00};
	localparam logic [9:0] ADDR_CELL_INTERVAL_COUNTER = {IDX_CELL_INTERVAL_COUNTER, 2'b00};
	localparam logic [9:0] ADDR_MEMORY_PLACEMENT_SELECT = {IDX_MEMORY_PLACEMENT_SELECT, 2'b00};
	localparam logic [9:0] ADDR_FREE_QUEUE_BASE = {IDX_FREE_QUEUE_BASE, 2'b00};
	// field layout
	localparam int PTR_W = 16;
	localparam int LEN_W = 4;
	localparam int BASE_W = 24;
	localparam int PLACE_W = 12;
	localparam int BYTE_ADDR_W = 32;
	localparam logic [3:0] LEN_MAX = 4'hf;
	// placement bit positions
	localparam int PLACE_RX_BUFFER = 0;
	localparam int PLACE_TX_BUFFER = 1;
	localparam int PLACE_RX_FREE_QUEUE = 2;
	localparam int PLACE_RX_MID_QUEUE = 3;
	localparam int PLACE_RX_READY_QUEUE = 4;
	localparam int PLACE_TX_WAITING_QUEUE = 5;
	localparam int PLACE_TX_READY_QUEUE = 6;
	localparam int PLACE_TX_FREE_QUEUE = 7;
	localparam int PLACE_TX_PDU_TABLE = 8;
	localparam int PLACE_TX_VPCI_TABLE = 9;
	localparam int PLACE_RX_VPCI_TABLE = 10;
	localparam int PLACE_RX_MID_TABLE = 11;
	// values after reset
	localparam logic [15:0] PTR_RESET = 16'h0000;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
	localparam logic [3:0] LEN_RESET = 4'h0;
	localparam logic [11:0] PLACE_RESET = 12'h000;
	localparam logic [23:0] BASE_RESET = 24'h00_0000;
	// byte address scale factors
	localparam int BASE_SHIFT = 8;
	localparam int ENTRY_SHIFT = 1;
	// descriptor store handshake states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_STORE = 2'b10
	} store_state_t;
endpackage

// ### rtl/cell_tick_sync.sv
// three-stage synchroniser and edge detector for the transmit cell clock
// assumes the cell clock is far slower than clk_sys
`timescale 1ns/100ps
`default_nettype none
module cell_tick_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// asynchronous cell clock in, one-cycle tick out
	input wire logic cell_clk,
	output logic cell_tick
);
	typedef struct packed {
		logic [2:0] stage;
		logic seen;
		logic tick;
	} sync_t;
	sync_t cur;
	sync_t nxt;

	always_comb begin
		nxt = cur;
		nxt.stage = {cur.stage[1:0], cell_clk};
		nxt.tick = 1'b0;
		// a change counts when the second and third stages agree
		if (cur.stage[1] == cur.stage[2]) begin
			if (cur.stage[2] && !cur.seen) begin
				nxt.tick = 1'b1;
			end
			nxt.seen = cur.stage[2];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign cell_tick = cur.tick;
endmodule
`default_nettype wire

// ### rtl/tx_free_queue.sv
// transmit free queue control, cell interval counter and placement register
// assumes an apb master on clk_sys and a segmenter that hands over descriptors
`timescale 1ns/100ps
`default_nettype none
module tx_free_queue
	import txfq_pkg::*;
#(
	parameter int PLACE_BITS = txfq_pkg::PLACE_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [txfq_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// segmenter descriptor handover
	input wire logic desc_valid,
	input wire logic [15:0] desc_data,
	output logic desc_ready,
	// memory write request for the descriptor
	output logic mem_wr_req,
	output logic [31:0] mem_wr_addr,
	output logic [15:0] mem_wr_data,
	output logic mem_wr_host,
	input wire logic mem_wr_ack,
	// cell clock and credit manager
	input wire logic cell_clk,
	output logic [31:0] cell_count,
	// placement selects
	output logic [PLACE_BITS-1:0] placement,
	// queue status
	output logic queue_nonempty
);
	import txfq_pkg::*;

	// -----------------------------------------------------------------
	// parameter check
	// -----------------------------------------------------------------
	if (PLACE_BITS != PLACE_W) begin : g_place_check
		$error("placement width must be twelve");
	end

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] length;
		logic [23:0] base;
		logic [15:0] rptr;
		logic [15:0] wptr;
		logic [31:0] count;
		logic [PLACE_BITS-1:0] place;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		store_state_t state;
		logic req;
		logic [31:0] addr;
		logic [15:0] data;
		logic dready;
		logic nonempty;
	} state_t;
	state_t cur;
	state_t nxt;

	// -----------------------------------------------------------------
	// cell clock synchroniser
	// -----------------------------------------------------------------
	logic cell_tick;

	cell_tick_sync u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.cell_clk(cell_clk),
		.cell_tick(cell_tick)
	);

	// -----------------------------------------------------------------
	// pointer helpers
	// -----------------------------------------------------------------
	function automatic logic [15:0] ptr_mask(input logic [3:0] len);
		logic [16:0] m;
		m = (17'h00002 << len) - 17'h00001;
		return m[15:0];
	endfunction

	function automatic logic [15:0] ptr_inc(input logic [15:0] p, input logic [3:0] len);
		logic [15:0] s;
		s = p + 16'h0001;
		return s & ptr_mask(len);
	endfunction

	function automatic logic queue_has_entries(input state_t s);
		return s.rptr != s.wptr;
	endfunction

	// -----------------------------------------------------------------
	// queue entry address
	// -----------------------------------------------------------------
	function automatic logic [31:0] entry_addr(input logic [23:0] b, input logic [15:0] p);
		logic [31:0] base_part;
		logic [31:0] slot_part;
		base_part = {8'h00, b} << BASE_SHIFT;
		slot_part = {16'h0000, p} << ENTRY_SHIFT;
		return base_part + slot_part;
	endfunction

	// -----------------------------------------------------------------
	// register decode
	// -----------------------------------------------------------------
	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		logic hit;
		case (a)
			ADDR_FREE_QUEUE_LENGTH,
			ADDR_FREE_QUEUE_AUTO_READ,
			ADDR_FREE_QUEUE_MANUAL_READ,
			ADDR_CELL_INTERVAL_COUNTER,
			ADDR_MEMORY_PLACEMENT_SELECT,
			ADDR_FREE_QUEUE_BASE: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a, input state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			ADDR_FREE_QUEUE_LENGTH: begin
				w = {28'h000_0000, s.length};
			end
			ADDR_FREE_QUEUE_AUTO_READ: begin
				w = {s.wptr, s.rptr};
			end
			ADDR_FREE_QUEUE_MANUAL_READ: begin
				w = {s.wptr, s.rptr};
			end
			ADDR_CELL_INTERVAL_COUNTER: begin
				w = s.count;
			end
			ADDR_MEMORY_PLACEMENT_SELECT: begin
				w = {{(32-PLACE_BITS){1'b0}}, s.place};
			end
			ADDR_FREE_QUEUE_BASE: begin
				w = {8'h00, s.base};
			end
			default: begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction

	// -----------------------------------------------------------------
	// descriptor store
	// -----------------------------------------------------------------
	function automatic state_t store_step(input state_t s, input logic valid,
		input logic [15:0] d, input logic ack);
		state_t n;
		n = s;
		n.dready = 1'b0;
		case (s.state)
			ST_IDLE: begin
				// a descriptor is taken only once the previous handover has ended
				if (valid && !s.dready) begin
					n.addr = entry_addr(s.base, s.wptr);
					n.data = d;
					n.req = 1'b1;
					n.state = ST_STORE;
				end
			end
			ST_STORE: begin
				if (ack) begin
					n.wptr = ptr_inc(s.wptr, s.length);
					n.req = 1'b0;
					n.dready = 1'b1;
					n.state = ST_IDLE;
				end
			end
			default: begin
				n.req = 1'b0;
				n.state = ST_IDLE;
			end
		endcase
		return n;
	endfunction

	// -----------------------------------------------------------------
	// register writes
	// -----------------------------------------------------------------
	function automatic state_t apb_write(input state_t s, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		state_t n;
		n = s;
		case (a)
			ADDR_FREE_QUEUE_LENGTH: begin
				n.length = d[3:0];
				n.rptr = PTR_RESET;
				n.wptr = PTR_RESET;
			end
			ADDR_FREE_QUEUE_AUTO_READ: begin
				n.wptr = d[15:0] & ptr_mask(s.length);
			end
			ADDR_FREE_QUEUE_MANUAL_READ: begin
				// upper half carries no meaning on a write
				n.rptr = d[15:0] & ptr_mask(s.length);
			end
			ADDR_MEMORY_PLACEMENT_SELECT: begin
				n.place = d[PLACE_BITS-1:0];
			end
			ADDR_FREE_QUEUE_BASE: begin
				n.base = d[23:0];
			end
			default: begin
				// counter and unmapped words take no write
				n.length = s.length;
			end
		endcase
		return n;
	endfunction

	// -----------------------------------------------------------------
	// register read side effects
	// -----------------------------------------------------------------
	function automatic state_t apb_read(input state_t s, input logic [ADDR_W-1:0] a);
		state_t n;
		n = s;
		// only the auto register moves the read pointer, never past the writer
		if (a == ADDR_FREE_QUEUE_AUTO_READ && s.rptr != s.wptr) begin
			n.rptr = ptr_inc(s.rptr, s.length);
		end
		return n;
	endfunction

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	logic setup_done;
	logic finish;

	always_comb begin
		setup_done = psel && penable && !cur.ready;
		finish = psel && penable && cur.ready;
		nxt = store_step(cur, desc_valid, desc_data, mem_wr_ack);
		nxt.ready = 1'b0;
		nxt.slverr = 1'b0;
		if (cell_tick) begin
			nxt.count = cur.count + 32'h0000_0001;
		end
		// answer one cycle after the access phase opens
		if (setup_done) begin
			nxt.ready = 1'b1;
			nxt.slverr = !addr_known(paddr);
			if (pwrite) begin
				nxt.rdata = 32'h0000_0000;
			end else begin
				nxt.rdata = read_word(paddr, cur);
			end
		end
		// effects land at the edge that samples pready high; a pointer write beats a store
		if (finish && addr_known(paddr)) begin
			if (pwrite) begin
				nxt = apb_write(nxt, paddr, pwdata);
			end else begin
				nxt = apb_read(nxt, paddr);
			end
		end
		nxt.nonempty = queue_has_entries(nxt);
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cur.length <= LEN_RESET;
			cur.base <= BASE_RESET;
			cur.rptr <= PTR_RESET;
			cur.wptr <= PTR_RESET;
			cur.count <= COUNT_RESET;
			cur.place <= PLACE_RESET;
			cur.rdata <= 32'h0000_0000;
			cur.ready <= 1'b0;
			cur.slverr <= 1'b0;
			cur.state <= ST_IDLE;
			cur.req <= 1'b0;
			cur.addr <= 32'h0000_0000;
			cur.data <= 16'h0000;
			cur.dready <= 1'b0;
			cur.nonempty <= 1'b0;
		end else begin
			cur <= nxt;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign prdata = cur.rdata;
	assign pready = cur.ready;
	assign pslverr = cur.slverr;
	assign desc_ready = cur.dready;
	assign mem_wr_req = cur.req;
	assign mem_wr_addr = cur.addr;
	assign mem_wr_data = cur.data;
	assign mem_wr_host = cur.place[PLACE_TX_FREE_QUEUE];
	assign cell_count = cur.count;
	assign queue_nonempty = cur.nonempty;
	for (genvar i = 0; i < PLACE_BITS; i++) begin : g_place
		assign placement[i] = cur.place[i];
	end
endmodule
`default_nettype wire

// ### dv/mem_model.sv
// memory responder for descriptor stores
// assumes one request level held until acknowledged
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	input wire logic clk_sys, reset_n, mem_wr_req, slow,
	output logic mem_wr_ack
);
	logic [2:0] cnt;
	logic done;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 3'h0;
			done <= 1'b0;
			mem_wr_ack <= 1'b0;
		end else begin
			mem_wr_ack <= 1'b0;
			if (!mem_wr_req) begin
				cnt <= 3'h0;
				done <= 1'b0;
			end else if (!done && cnt >= (slow ? 3'h4 : 3'h0)) begin
				mem_wr_ack <= 1'b1;
				done <= 1'b1;
			end else cnt <= cnt + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ### dv/tx_free_queue_sva.sv
// port checker of the free queue block
// assumes the ports of tx_free_queue
`timescale 1ns/100ps
`default_nettype none
module tx_free_queue_sva
	import txfq_pkg::*;
#(parameter int PLACE_BITS = txfq_pkg::PLACE_W) (
	input wire logic clk_sys, reset_n, psel, penable, pwrite, pready,
	input wire logic [txfq_pkg::ADDR_W-1:0] paddr,
	input wire logic desc_ready, mem_wr_req, mem_wr_host, mem_wr_ack, queue_nonempty,
	input wire logic [31:0] mem_wr_addr, cell_count,
	input wire logic [PLACE_BITS-1:0] placement
);
	wire taken = psel && penable && !pready;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	chk_apb_wait: assert property (taken |=> pready) else $error("pready late");
	chk_pready_pulse: assert property (pready |=> !pready) else $error("pready long");
	chk_len_clear: assert property (taken && pwrite && paddr == ADDR_FREE_QUEUE_LENGTH
		|-> ##[1:2] !queue_nonempty) else $error("queue not cleared");
	chk_ack_ready: assert property (mem_wr_req && mem_wr_ack |=> desc_ready)
		else $error("no desc_ready");
	chk_ready_cause: assert property (desc_ready |-> $past(mem_wr_ack))
		else $error("stray desc_ready");
	chk_req_hold: assert property (mem_wr_req && !mem_wr_ack
		|=> mem_wr_req && $stable(mem_wr_addr)) else $error("store dropped");
	chk_entry_even: assert property (mem_wr_req |-> !mem_wr_addr[0])
		else $error("odd entry address");
	chk_host_sel: assert property (mem_wr_req |-> mem_wr_host == placement[7])
		else $error("wrong memory select");
	chk_cell_step: assert property ($changed(cell_count)
		|-> cell_count == $past(cell_count) + 32'h1) else $error("cell count jump");
	cover property (desc_ready);
	cover property ($changed(cell_count));
	cover property (mem_wr_req && mem_wr_host);
endmodule
`default_nettype wire

// ### dv/transmit_free_queue_and_placement_tb_top.sv
// self-checking bench of the free queue block
// assumes txfq_pkg, mem_model and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module transmit_free_queue_and_placement_tb_top;
	import txfq_pkg::*;
	logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic desc_valid = 0, cell_clk = 0, slow = 0, pready, pslverr, desc_ready;
	logic mem_wr_req, mem_wr_host, mem_wr_ack, queue_nonempty;
	logic [9:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, mem_wr_addr, cell_count, r, s;
	logic [15:0] desc_data = 0, mem_wr_data;
	logic [11:0] placement, p;
	logic [23:0] base;
	int err_total = 0, n_compared = 0;
	tx_free_queue dut (.*);
	mem_model u_mem (.*);
	initial forever #50 clk_sys = ~clk_sys;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] slot(input logic [15:0] w);
		return {base, 8'h00} + {w, 1'b0};
	endfunction
	task automatic chk(input string nm, input logic [31:0] x, g);
		n_compared++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic push(input logic [15:0] d, w);
		@(posedge clk_sys);
		{desc_valid, desc_data} <= {1'b1, d};
		do @(posedge clk_sys); while (mem_wr_req !== 1'b1);
		chk("mem_wr_addr", slot(w), mem_wr_addr);
		chk("mem_wr_data", {16'h0, d}, {16'h0, mem_wr_data});
		chk("mem_wr_host", {31'h0, p[7]}, {31'h0, mem_wr_host});
		do @(posedge clk_sys); while (desc_ready !== 1'b1);
		desc_valid <= 1'b0;
	endtask
	task conclude;
		$display("mismatches %0d of %0d compared", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		apb(0, ADDR_FREE_QUEUE_AUTO_READ, 0);
		chk("pointers", 0, r);
		apb(0, ADDR_CELL_INTERVAL_COUNTER, 0);
		chk("cell reset", 0, r);
		s = lfsr(32'd30);
		base = s[23:0];
		apb(1, ADDR_FREE_QUEUE_BASE, {8'h00, base});
		for (int k = 0; k < 2; k++) begin
			s = lfsr(s);
			p = (k == 0) ? {s[11:8], k[0], s[6:0]} : {4'h0, k[0], s[6:3], 1'b0, s[1:0]};
			apb(1, ADDR_MEMORY_PLACEMENT_SELECT, {20'h0, p});
			apb(0, ADDR_MEMORY_PLACEMENT_SELECT, 0);
			chk("placement reg", {20'h0, p}, r);
			chk("placement", {20'h0, p}, {20'h0, placement});
		end
		apb(1, ADDR_FREE_QUEUE_LENGTH, 32'h1);
		for (int i = 0; i < 3; i++) begin
			slow <= i[0];
			s = lfsr(s);
			push(s[15:0], i[15:0]);
		end
		chk("nonempty", 1, {31'h0, queue_nonempty});
		apb(0, ADDR_FREE_QUEUE_AUTO_READ, 0);
		chk("auto read", 32'h0003_0000, r);
		apb(0, ADDR_FREE_QUEUE_AUTO_READ, 0);
		chk("auto read", 32'h0003_0001, r);
		for (int j = 0; j < 2; j++) begin
			apb(0, ADDR_FREE_QUEUE_MANUAL_READ, 0);
			chk("manual read", 32'h0003_0002, r);
		end
		s = lfsr(s);
		push(s[15:0], 16'h3);
		apb(1, ADDR_FREE_QUEUE_MANUAL_READ, 32'hffff_0003);
		apb(0, ADDR_FREE_QUEUE_MANUAL_READ, 0);
		chk("manual write", 32'h0000_0003, r);
		for (int j = 0; j < 3; j++) begin
			apb(0, ADDR_FREE_QUEUE_AUTO_READ, 0);
			chk("auto wrap", (j == 0) ? 32'h3 : 32'h0, r);
		end
		chk("empty", 0, {31'h0, queue_nonempty});
		apb(1, ADDR_FREE_QUEUE_AUTO_READ, 32'h0002_0002);
		apb(0, ADDR_FREE_QUEUE_MANUAL_READ, 0);
		chk("wptr load", 32'h2, {16'h0, r[31:16]});
		apb(1, ADDR_FREE_QUEUE_LENGTH, 32'hf);
		apb(0, ADDR_FREE_QUEUE_AUTO_READ, 0);
		chk("length clear", 0, r);
		apb(1, ADDR_FREE_QUEUE_MANUAL_READ, 32'h0000_ffff);
		apb(0, ADDR_FREE_QUEUE_MANUAL_READ, 0);
		chk("rptr max", 32'h0000_ffff, r);
		apb(0, 10'h000, 0);
		chk("unmapped", 1, {31'h0, e});
		apb(1, ADDR_CELL_INTERVAL_COUNTER, 32'h5a5a_5a5a);
		chk("counter write", 0, {31'h0, e});
		repeat (3) begin
			repeat (10) @(posedge clk_sys);
			cell_clk <= 1'b1;
			repeat (10) @(posedge clk_sys);
			cell_clk <= 1'b0;
		end
		repeat (10) @(posedge clk_sys);
		apb(0, ADDR_CELL_INTERVAL_COUNTER, 0);
		chk("cell count", 32'h3, r);
		chk("cell port", 32'h3, cell_count);
		conclude();
	end
endmodule
bind tx_free_queue tx_free_queue_sva #(.PLACE_BITS(PLACE_BITS)) u_sva (.*);
`default_nettype wire
